// file: src/dram_err_pkg.sv
// Constants and types for the DRAM error reporting logic.
`default_nettype none
package dram_err_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_MEM_ESR    = 8'h00;
  localparam logic [7:0] OFF_MEM_EAR_LO = 8'h04;
  localparam logic [7:0] OFF_MEM_EAR_HI = 8'h08;
  localparam logic [7:0] OFF_LINK_SYND  = 8'h0C;
  localparam logic [7:0] OFF_CACHE_ESR  = 8'h10;
  localparam logic [7:0] OFF_CACHE_EAR_LO = 8'h14;
  localparam logic [7:0] OFF_CACHE_EAR_HI = 8'h18;
  localparam logic [7:0] OFF_CACHE_CTRL = 8'h1C;
  localparam logic [7:0] OFF_CORE_EN    = 8'h20;
  localparam logic [7:0] OFF_TRAP_EN    = 8'h24;
  localparam logic [7:0] OFF_DESR       = 8'h28;
  localparam logic [7:0] OFF_FAULT      = 8'h2C;
  // Memory error status flags, bits 21:16 of the status word.
  localparam int MEM_FLAG_POS = 16;
  localparam int MF_DSC = 0;
  localparam int MF_FBR = 1;
  localparam int MF_DAU = 2;
  localparam int MF_VEU = 3;
  localparam int MF_DBU = 4;
  localparam int MF_FBU = 5;
  // Cache error status fields.
  localparam int CF_DSC = 0;
  localparam int CF_DAU = 1;
  localparam int CF_VEU = 2;
  localparam int CACHE_RW_POS   = 3;
  localparam int CACHE_MODA_POS = 4;
  localparam int CACHE_VCID_POS = 8;
  // Control fields.
  localparam int CTRL_CEEN  = 0;
  localparam int CTRL_NCEEN = 1;
  localparam int CTRL_STEER_POS = 8;
  localparam int CE_CORR  = 0;
  localparam int CE_UNCORR = 1;
  localparam int CE_FETCH = 2;
  localparam int CE_DATA  = 3;
  localparam int TE_DHCCE = 0;
  localparam int TE_DE    = 1;
  localparam int TE_PSCCE = 2;
  localparam int DESR_VALID_POS = 31;
  localparam int FAULT_DATA_POS = 4;
  // Reset values.
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [3:0]  CORE_EN_RST = 4'h0;
  localparam logic [2:0]  TRAP_EN_RST = 3'h0;
  // Error codes carried in packets and fault status.
  localparam logic [3:0] CODE_NONE          = 4'h0;
  localparam logic [3:0] CODE_CACHE_CORR    = 4'h1;
  localparam logic [3:0] CODE_CACHE_UNCORR  = 4'h2;
  localparam logic [3:0] CODE_FETCH_UNCORR  = 4'h3;
  localparam logic [3:0] CODE_DATA_UNCORR   = 4'h4;
  typedef enum logic [3:0] {
    K_LOAD, K_FETCH, K_PREFETCH, K_ATOMIC, K_TTE,
    K_STORE, K_PSTORE, K_WRBACK, K_BSTORE
  } access_kind_e;
  typedef enum logic [1:0] {
    LC_DATA_CRC, LC_ALERT_FRAME, LC_ALERT_STATUS, LC_STATUS_PARITY
  } link_cond_e;
endpackage
`default_nettype wire

// file: src/dram_err_report.sv
// DRAM error classification, logging and trap reporting with an APB slave.
// Behaviour
// - scrub correctable error logs flag, syndrome and address bits 39:4.
// - recovered link error sets link flag, saves syndrome, reports correctable.
// - correctable report sets cache flag; only scrub errors trigger corrected memory rewrite.
// - with correctable enable, send indication packet to steered processor.
// - corrected error logs its code when report enabled and status invalid.
// - corrected trap needs its enable and interrupts on or not hyperprivileged.
// - unmet trap stays pending until status cleared or enables allow it.
// - cache scrub flag is set regardless of other cache status bits.
// - four link conditions, when recovered, log and report correctable.
// - ECC and link uncorrectable errors report uncorrectable with own logs.
// - out-of-bounds read poisons whole line and sets bounds flag.
// - writebacks and block stores out of bounds dropped without indication.
// - before-fill critical error logs flags, requester, mode, address 39:6.
// - before-fill error chunks get corrupted ECC, first level bad parity.
// - with uncorrectable enable, error returns in the load return packet.
// - fetch error with enables records code and traps, else nothing.
// - data fetch error with enables records code and traps, else nothing.
// - after-fill misses log steered requester and signal disrupting error.
// - uncorrectable error logged when enabled and status invalid; gated trap.
// - atomic on erroneous word leaves data and bad ECC unchanged.
// - store miss poisons error chunks; partial store abandons its update.
// - prefetch error places no data in the first level data cache.
`default_nettype none
module dram_err_report
  import dram_err_pkg::*;
#(
  parameter int LINE_CHUNKS = 16,
  parameter int SYND_W      = 16,
  parameter int LSYND_W     = 8,
  parameter int VCID_W      = 6
) (
  // Clock and reset.
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave.
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  // Correctable events from the memory controller.
  input  wire logic                 ce_valid,
  input  wire logic                 ce_is_link,
  input  wire link_cond_e           ce_link_cond,
  input  wire logic [SYND_W-1:0]    ce_synd,
  input  wire logic [LSYND_W-1:0]   ce_link_synd,
  input  wire logic [39:4]          ce_addr,
  // Uncorrectable access events.
  input  wire logic                 acc_valid,
  input  wire access_kind_e         acc_kind,
  input  wire logic                 acc_ecc_ue,
  input  wire logic                 acc_link_ue,
  input  wire logic                 acc_oob,
  input  wire logic                 acc_before_fill,
  input  wire logic                 acc_crit_err,
  input  wire logic [LINE_CHUNKS-1:0] acc_chunk_err,
  input  wire logic [SYND_W-1:0]    acc_synd,
  input  wire logic [LSYND_W-1:0]   acc_link_synd,
  input  wire logic [39:6]          acc_addr,
  input  wire logic [VCID_W-1:0]    acc_vcid,
  input  wire logic                 acc_mode,
  // Strand state.
  input  wire logic                 interrupt_enable_flag,
  input  wire logic                 hyperpriv_mode_flag,
  // Correction and cache fill actions.
  output var  logic                 mem_rewrite,
  output var  logic                 chunk_poison,
  output var  logic                 chunk_corrupt,
  output var  logic [LINE_CHUNKS-1:0] chunk_mask,
  output var  logic                 l1_bad_parity,
  output var  logic                 l1_fill_inhibit,
  output var  logic                 update_abort,
  output var  logic                 access_drop,
  // Packets to processors.
  output var  logic                 corr_pkt_valid,
  output var  logic [VCID_W-1:0]    corr_pkt_vcid,
  output var  logic [3:0]           corr_pkt_code,
  output var  logic                 load_ret_err,
  output var  logic [3:0]           load_ret_code,
  // Traps.
  output var  logic                 instr_trap,
  output var  logic                 data_trap,
  output var  logic                 hw_corr_trap,
  output var  logic                 sw_rec_trap
);
  if (LINE_CHUNKS < 1 || LINE_CHUNKS > 32 || SYND_W < 1 || SYND_W > 16 ||
      LSYND_W < 1 || LSYND_W > 30 || VCID_W < 1 || VCID_W > 8) begin : g_chk
    $error("dram_err_report: unsupported parameter values");
  end

  function automatic logic [5:0] w1c6(input logic [5:0] cur,
                                      input logic [5:0] set,
                                      input logic [5:0] clr);
    w1c6 = (cur & ~clr) | set;
  endfunction

  function automatic logic gate_ok(input logic en);
    gate_ok = en && (interrupt_enable_flag || !hyperpriv_mode_flag);
  endfunction

  logic [5:0]         mem_flags_r;
  logic [SYND_W-1:0]  mem_synd_r;
  logic [39:4]        mem_addr_r;
  logic [LSYND_W-1:0] link_synd_r;
  logic [1:0]         link_cond_r;
  logic [5:0]         cache_flags_r;
  logic               cache_rw_r;
  logic               cache_moda_r;
  logic [VCID_W-1:0]  cache_vcid_r;
  logic [39:6]        cache_addr_r;
  logic [31:0]        ctrl_r;
  logic [3:0]         core_en_r;
  logic [2:0]         trap_en_r;
  logic               desr_valid_r;
  logic [3:0]         desr_code_r;
  logic               pend_r;
  logic [3:0]         ifault_r;
  logic [3:0]         dfault_r;

  // APB decode.
  logic wr;
  logic [31:0] clr_w;
  assign wr = psel && penable && pready && pwrite;
  assign clr_w = pwdata;

  // Event classification.
  logic ue;
  logic drop;
  logic ue_live;
  logic bf;
  logic af;
  logic [VCID_W-1:0] steer;
  assign steer = ctrl_r[CTRL_STEER_POS +: VCID_W];
  assign ue = acc_ecc_ue || acc_link_ue || acc_oob;
  assign drop = acc_valid && acc_oob &&
                (acc_kind == K_WRBACK || acc_kind == K_BSTORE);
  assign ue_live = acc_valid && ue && !drop;
  assign bf = ue_live && acc_before_fill && acc_crit_err &&
              (acc_kind == K_LOAD || acc_kind == K_FETCH ||
               acc_kind == K_PREFETCH);
  assign af = ue_live && !bf;

  // Disrupting status logging.
  logic log_corr;
  logic log_uncorr;
  assign log_uncorr = af && ctrl_r[CTRL_NCEEN] &&
                      core_en_r[CE_UNCORR] && !desr_valid_r;
  assign log_corr = ce_valid && ctrl_r[CTRL_CEEN] &&
                    core_en_r[CE_CORR] && !desr_valid_r;

  logic take_hw;
  logic take_sw;
  assign take_hw = pend_r && desr_code_r == CODE_CACHE_CORR &&
                   gate_ok(trap_en_r[TE_DHCCE]);
  assign take_sw = pend_r && desr_code_r == CODE_CACHE_UNCORR &&
                   gate_ok(trap_en_r[TE_DE]);

  // Memory error status and address.
  logic [5:0] mem_set;
  always_comb begin
    mem_set = '0;
    mem_set[MF_DSC] = ce_valid && !ce_is_link;
    mem_set[MF_FBR] = ce_valid && ce_is_link;
    mem_set[MF_DAU] = ue_live && acc_ecc_ue;
    mem_set[MF_VEU] = ue_live && acc_ecc_ue;
    mem_set[MF_DBU] = ue_live && acc_oob;
    mem_set[MF_FBU] = ue_live && acc_link_ue;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_flags_r <= '0;
    end else begin
      mem_flags_r <= w1c6(mem_flags_r, mem_set,
        (wr && paddr == OFF_MEM_ESR) ? clr_w[MEM_FLAG_POS +: 6] : 6'h00);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_synd_r <= '0;
      mem_addr_r <= '0;
    end else if (ue_live && acc_ecc_ue) begin
      mem_synd_r <= acc_synd;
    end else if (ce_valid && !ce_is_link) begin
      mem_synd_r <= ce_synd;
      mem_addr_r <= ce_addr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_synd_r <= '0;
      link_cond_r <= '0;
    end else if (ue_live && acc_link_ue) begin
      link_synd_r <= acc_link_synd;
    end else if (ce_valid && ce_is_link) begin
      link_synd_r <= ce_link_synd;
      link_cond_r <= ce_link_cond;
    end
  end

  // Cache error status and address.
  logic [5:0] cache_set;
  always_comb begin
    cache_set = '0;
    cache_set[CF_DSC] = ce_valid;
    cache_set[CF_DAU] = ue_live;
    cache_set[CF_VEU] = ue_live;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cache_flags_r <= '0;
    end else begin
      cache_flags_r <= w1c6(cache_flags_r, cache_set,
        (wr && paddr == OFF_CACHE_ESR) ? clr_w[5:0] : 6'h00);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cache_rw_r   <= 1'b0;
      cache_moda_r <= 1'b0;
      cache_vcid_r <= '0;
      cache_addr_r <= '0;
    end else if (bf) begin
      cache_rw_r   <= 1'b0;
      cache_moda_r <= acc_mode;
      cache_vcid_r <= acc_vcid;
      cache_addr_r <= acc_addr;
    end else if (af) begin
      cache_rw_r   <= acc_kind == K_STORE || acc_kind == K_PSTORE;
      cache_vcid_r <= steer;
      cache_addr_r <= acc_addr;
    end
  end

  // Software control registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= CTRL_RST;
      core_en_r <= CORE_EN_RST;
      trap_en_r <= TRAP_EN_RST;
    end else if (wr) begin
      if (paddr == OFF_CACHE_CTRL) begin
        ctrl_r <= pwdata;
      end
      if (paddr == OFF_CORE_EN) begin
        core_en_r <= pwdata[3:0];
      end
      if (paddr == OFF_TRAP_EN) begin
        trap_en_r <= pwdata[2:0];
      end
    end
  end

  // Disrupting status register and pending trap request.
  logic desr_clr;
  assign desr_clr = wr && paddr == OFF_DESR && !pwdata[DESR_VALID_POS];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      desr_valid_r <= 1'b0;
      desr_code_r  <= CODE_NONE;
    end else if (log_uncorr) begin
      desr_valid_r <= 1'b1;
      desr_code_r  <= CODE_CACHE_UNCORR;
    end else if (log_corr) begin
      desr_valid_r <= 1'b1;
      desr_code_r  <= CODE_CACHE_CORR;
    end else if (desr_clr) begin
      desr_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 1'b0;
    end else if (log_uncorr || log_corr) begin
      pend_r <= 1'b1;
    end else if (desr_clr || take_hw || take_sw) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_corr_trap <= 1'b0;
      sw_rec_trap  <= 1'b0;
    end else begin
      hw_corr_trap <= take_hw && !desr_clr;
      sw_rec_trap  <= take_sw && !desr_clr;
    end
  end

  // Precise fetch and data traps.
  logic fetch_hit;
  logic data_hit;
  assign fetch_hit = bf && ctrl_r[CTRL_NCEEN] && acc_kind == K_FETCH &&
                     core_en_r[CE_FETCH] && trap_en_r[TE_PSCCE];
  assign data_hit = bf && ctrl_r[CTRL_NCEEN] && acc_kind != K_FETCH &&
                    core_en_r[CE_DATA] && trap_en_r[TE_PSCCE];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifault_r   <= CODE_NONE;
      dfault_r   <= CODE_NONE;
      instr_trap <= 1'b0;
      data_trap  <= 1'b0;
    end else begin
      instr_trap <= fetch_hit;
      data_trap  <= data_hit;
      if (fetch_hit) begin
        ifault_r <= CODE_FETCH_UNCORR;
      end else if (wr && paddr == OFF_FAULT) begin
        ifault_r <= CODE_NONE;
      end
      if (data_hit) begin
        dfault_r <= CODE_DATA_UNCORR;
      end else if (wr && paddr == OFF_FAULT) begin
        dfault_r <= CODE_NONE;
      end
    end
  end

  // Cache fill actions and outgoing packets.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rewrite     <= 1'b0;
      chunk_poison    <= 1'b0;
      chunk_corrupt   <= 1'b0;
      chunk_mask      <= '0;
      l1_bad_parity   <= 1'b0;
      l1_fill_inhibit <= 1'b0;
      update_abort    <= 1'b0;
      access_drop     <= 1'b0;
      corr_pkt_valid  <= 1'b0;
      corr_pkt_vcid   <= '0;
      corr_pkt_code   <= CODE_NONE;
      load_ret_err    <= 1'b0;
      load_ret_code   <= CODE_NONE;
    end else begin
      mem_rewrite   <= ce_valid && !ce_is_link;
      access_drop   <= drop;
      chunk_poison  <= ue_live;
      chunk_corrupt <= bf;
      chunk_mask    <= acc_oob ? '1 : acc_chunk_err;
      l1_bad_parity <= bf && acc_kind != K_PREFETCH;
      l1_fill_inhibit <= ue_live && acc_kind == K_PREFETCH;
      update_abort  <= ue_live &&
                       (acc_kind == K_ATOMIC || acc_kind == K_PSTORE);
      corr_pkt_valid <= ce_valid && ctrl_r[CTRL_CEEN];
      corr_pkt_vcid  <= steer;
      corr_pkt_code  <= CODE_CACHE_CORR;
      load_ret_err   <= bf && ctrl_r[CTRL_NCEEN];
      load_ret_code  <= CODE_CACHE_UNCORR;
    end
  end

  // APB read mux, no wait states.
  logic [31:0] rd;
  logic        hit;
  always_comb begin
    rd  = '0;
    hit = 1'b1;
    unique case (paddr)
      OFF_MEM_ESR: begin
        rd[MEM_FLAG_POS +: 6] = mem_flags_r;
        rd[SYND_W-1:0] = mem_synd_r;
      end
      OFF_MEM_EAR_LO:   rd = mem_addr_r[35:4];
      OFF_MEM_EAR_HI:   rd[3:0] = mem_addr_r[39:36];
      OFF_LINK_SYND: begin
        rd[LSYND_W-1:0] = link_synd_r;
        rd[31:30] = link_cond_r;
      end
      OFF_CACHE_ESR: begin
        rd[5:0] = cache_flags_r;
        rd[CACHE_RW_POS] = cache_rw_r;
        rd[CACHE_MODA_POS] = cache_moda_r;
        rd[CACHE_VCID_POS +: VCID_W] = cache_vcid_r;
      end
      OFF_CACHE_EAR_LO: rd = cache_addr_r[37:6];
      OFF_CACHE_EAR_HI: rd[1:0] = cache_addr_r[39:38];
      OFF_CACHE_CTRL:   rd = ctrl_r;
      OFF_CORE_EN:      rd[3:0] = core_en_r;
      OFF_TRAP_EN:      rd[2:0] = trap_en_r;
      OFF_DESR: begin
        rd[DESR_VALID_POS] = desr_valid_r;
        rd[3:0] = desr_code_r;
      end
      OFF_FAULT: begin
        rd[3:0] = ifault_r;
        rd[FAULT_DATA_POS +: 4] = dfault_r;
      end
      default:          hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata  <= (psel && !penable && !pwrite) ? rd : 32'h0000_0000;
    end
  end

  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ce_scrub;
    ce_valid && !ce_is_link;
  endsequence
  sequence s_rewrite_seen;
    ##1 mem_rewrite && cache_flags_r[CF_DSC] && mem_flags_r[MF_DSC];
  endsequence

  a_scrub_logging: assert property (s_ce_scrub |-> s_rewrite_seen)
    else $error("scrub error not logged");
  a_link_recov: assert property (ce_valid && ce_is_link |=>
    mem_flags_r[MF_FBR] && cache_flags_r[CF_DSC] && !mem_rewrite)
    else $error("link recovery not logged");
  a_corr_packet: assert property (ce_valid && ctrl_r[CTRL_CEEN] |=>
    corr_pkt_valid && corr_pkt_vcid == $past(steer))
    else $error("corrected packet missing");
  a_hw_trap_gate: assert property (hw_corr_trap |->
    $past(pend_r) && $past(trap_en_r[TE_DHCCE]) &&
    ($past(interrupt_enable_flag) || !$past(hyperpriv_mode_flag)))
    else $error("hw corrected trap without gate");
  a_pend_hold: assert property (pend_r && !take_hw && !take_sw &&
    !desr_clr |=> pend_r)
    else $error("pending trap lost");
  a_oob_drop: assert property (drop |=> access_drop && !chunk_poison &&
    !load_ret_err)
    else $error("out of bounds write not dropped");
  a_oob_poison: assert property (ue_live && acc_oob |=>
    chunk_poison && chunk_mask == '1 && mem_flags_r[MF_DBU])
    else $error("out of bounds line not poisoned");
  a_load_return: assert property (bf && ctrl_r[CTRL_NCEEN] |=>
    load_ret_err && chunk_corrupt)
    else $error("load return error missing");
  a_fetch_trap: assert property (instr_trap |-> ifault_r ==
    CODE_FETCH_UNCORR && $past(trap_en_r[TE_PSCCE]))
    else $error("fetch trap without record");
  a_prefetch_l1: assert property (ue_live && acc_kind == K_PREFETCH |=>
    l1_fill_inhibit)
    else $error("prefetch filled first level cache");
endmodule
`default_nettype wire

// file: sim/mem_ctrl_model.sv
// Memory controller model that raises error events toward the block.
`default_nettype none
module mem_ctrl_model
  import dram_err_pkg::*;
(
  // Clock.
  input  wire logic         pclk,
  // Correctable events.
  output var  logic         ce_valid,
  output var  logic         ce_is_link,
  output var  link_cond_e   ce_link_cond,
  output var  logic [15:0]  ce_synd,
  output var  logic [7:0]   ce_link_synd,
  output var  logic [39:4]  ce_addr,
  // Uncorrectable events.
  output var  logic         acc_valid,
  output var  access_kind_e acc_kind,
  output var  logic [4:0]   acc_flags,
  output var  logic [15:0]  acc_chunk_err,
  output var  logic [15:0]  acc_synd,
  output var  logic [7:0]   acc_link_synd,
  output var  logic [39:6]  acc_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {ce_valid, ce_is_link, acc_valid, acc_flags} = '0;
    ce_link_cond = LC_DATA_CRC;
    acc_kind = K_LOAD;
    {ce_synd, ce_link_synd, ce_addr} = '0;
    {acc_chunk_err, acc_synd, acc_link_synd, acc_addr} = '0;
  end
  // Sends a scrub error or one recovered link condition for one cycle.
  task automatic corr(input logic link, input link_cond_e c);
    @(posedge pclk);
    {ce_valid, ce_is_link} <= {1'b1, link};
    ce_link_cond <= c;
    {ce_synd, ce_link_synd} <= {16'h5a3c, 8'hc3};
    ce_addr <= 36'h8_1234_5670;
    @(posedge pclk);
    ce_valid <= 1'b0;
    ce_addr <= ~ce_addr;
    {ce_synd, ce_link_synd} <= ~{ce_synd, ce_link_synd};
  endtask
  // Sends one uncorrectable access event for one cycle.
  task automatic acc(input access_kind_e k, input logic [4:0] f,
                     input logic [15:0] ch);
    @(posedge pclk);
    {acc_valid, acc_flags, acc_chunk_err} <= {1'b1, f, ch};
    acc_kind <= k;
    {acc_synd, acc_link_synd} <= {16'h1e2d, 8'h96};
    acc_addr <= 34'h2_abcd_ef01;
    @(posedge pclk);
    acc_valid <= 1'b0;
    {acc_flags, acc_addr} <= ~{acc_flags, acc_addr};
    {acc_synd, acc_link_synd} <= ~{acc_synd, acc_link_synd};
  endtask
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the DRAM error reporting logic.
`default_nettype none
module testbench
  import dram_err_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         pclk, presetn, psel, penable, pwrite, ie, hp, err;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic         pready, pslverr, ce_valid, ce_is_link, acc_valid;
  link_cond_e   ce_link_cond;
  access_kind_e acc_kind;
  logic [4:0]   af;
  logic [15:0]  ce_synd, acc_synd, acc_chunk_err, chunk_mask;
  logic [7:0]   ce_link_synd, acc_link_synd;
  logic [39:4]  ce_addr;
  logic [39:6]  acc_addr;
  logic [5:0]   corr_pkt_vcid;
  logic [3:0]   corr_pkt_code, load_ret_code, tr;
  logic         mem_rewrite, chunk_poison, chunk_corrupt, l1_bad_parity;
  logic         l1_fill_inhibit, update_abort, access_drop, corr_pkt_valid;
  logic         load_ret_err, instr_trap, data_trap, hw_corr_trap, sw_rec_trap;
  int           n_fail = 0;
  int           checked = 0;
  dram_err_report u_dram_err_report (.*, .acc_ecc_ue(af[4]),
    .acc_link_ue(af[3]), .acc_oob(af[2]), .acc_before_fill(af[1]),
    .acc_crit_err(af[0]), .acc_vcid(6'h15), .acc_mode(1'b1),
    .interrupt_enable_flag(ie), .hyperpriv_mode_flag(hp));
  mem_ctrl_model u_mem_ctrl_model (.pclk, .ce_valid, .ce_is_link,
    .ce_link_cond, .ce_synd, .ce_link_synd, .ce_addr, .acc_valid,
    .acc_kind, .acc_flags(af), .acc_chunk_err, .acc_synd, .acc_link_synd,
    .acc_addr);
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (e !== g) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  // Gathers trap pulses over the next four edges.
  task automatic win();
    tr = '0;
    repeat (4) begin
      @(posedge pclk);
      tr |= {instr_trap, data_trap, hw_corr_trap, sw_rec_trap};
    end
  endtask
  task automatic t_scrub();
    apb(0, 8'h3c, '0);
    chk("unmapped", 32'h0000_0000, rd);
    chk("slverr", 1'b1, err);
    apb(1, OFF_CACHE_CTRL, 32'h0000_2a03);
    apb(1, OFF_CORE_EN, 32'h0000_000f);
    apb(1, OFF_TRAP_EN, 32'h0000_0007);
    u_mem_ctrl_model.corr(1'b0, LC_DATA_CRC);
    #1;
    chk("rewrite", 1'b1, mem_rewrite);
    chk("pkt", {7'h6a, CODE_CACHE_CORR},
        {corr_pkt_valid, corr_pkt_vcid, corr_pkt_code});
    win();
    chk("hw trap", 4'b0010, tr);
    apb(0, OFF_MEM_ESR, '0);
    chk("mem esr", 32'h0001_5a3c, rd);
    apb(0, OFF_MEM_EAR_LO, '0);
    chk("ear lo", 32'h1234_5670, rd);
    apb(0, OFF_MEM_EAR_HI, '0);
    chk("ear hi", 4'h8, rd[3:0]);
    apb(0, OFF_CACHE_ESR, '0);
    chk("cache dsc", 1'b1, rd[CF_DSC]);
    apb(0, OFF_DESR, '0);
    chk("desr", 5'h11, {rd[31], rd[3:0]});
    apb(1, OFF_DESR, '0);
  endtask
  task automatic t_precise();
    u_mem_ctrl_model.acc(K_LOAD, 5'b10011, 16'h0081);
    #1;
    chk("ret", {1'b1, CODE_CACHE_UNCORR}, {load_ret_err, load_ret_code});
    chk("corrupt", {2'b11, 16'h0081},
        {chunk_corrupt, l1_bad_parity, chunk_mask});
    win();
    chk("data trap", 2'b01, tr[3:2]);
    apb(0, OFF_FAULT, '0);
    chk("dfault", CODE_DATA_UNCORR, rd[7:4]);
    apb(0, OFF_CACHE_ESR, '0);
    chk("cache esr", {6'h15, 7'h0b}, rd[13:1]);
    apb(0, OFF_CACHE_EAR_LO, '0);
    chk("cache ear", 32'habcd_ef01, rd);
    apb(1, OFF_FAULT, '0);
    apb(1, OFF_CORE_EN, 32'h0000_000b);
    u_mem_ctrl_model.acc(K_FETCH, 5'b10011, 16'h0001);
    win();
    chk("no ftrap", 1'b0, tr[3]);
    apb(1, OFF_CORE_EN, 32'h0000_000f);
    u_mem_ctrl_model.acc(K_FETCH, 5'b10011, 16'h0001);
    win();
    chk("ftrap", 1'b1, tr[3]);
    apb(0, OFF_FAULT, '0);
    chk("ifault", CODE_FETCH_UNCORR, rd[3:0]);
  endtask
  task automatic t_pend();
    apb(1, OFF_DESR, '0);
    {ie, hp} <= 2'b01;
    apb(1, OFF_CACHE_ESR, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      u_mem_ctrl_model.corr(1'b1, link_cond_e'(i));
      #1;
      chk("link pkt", 2'b10, {corr_pkt_valid, mem_rewrite});
      apb(0, OFF_LINK_SYND, '0);
      chk("link synd", {i[1:0], 8'hc3}, {rd[31:30], rd[7:0]});
    end
    apb(0, OFF_MEM_ESR, '0);
    chk("fbr", 1'b1, rd[MEM_FLAG_POS + MF_FBR]);
    apb(0, OFF_CACHE_ESR, '0);
    chk("dsc kept", 2'b11, {rd[CF_DSC], rd[CF_DAU]});
    apb(1, OFF_DESR, '0);
    hp <= 1'b0;
    win();
    chk("cancelled", 4'b0000, tr);
    hp <= 1'b1;
    u_mem_ctrl_model.corr(1'b1, LC_ALERT_FRAME);
    win();
    chk("held", 4'b0000, tr);
    hp <= 1'b0;
    win();
    chk("released", 4'b0010, tr);
    apb(1, OFF_DESR, '0);
    {ie, hp} <= 2'b11;
  endtask
  task automatic t_after();
    u_mem_ctrl_model.acc(K_PREFETCH, 5'b10000, 16'h0010);
    #1;
    chk("no l1 fill", 1'b1, l1_fill_inhibit);
    win();
    chk("sw trap", 1'b1, tr[0]);
    apb(0, OFF_DESR, '0);
    chk("desr", 5'h12, {rd[31], rd[3:0]});
    apb(0, OFF_CACHE_ESR, '0);
    chk("steered", 6'h2a, rd[13:8]);
    u_mem_ctrl_model.acc(K_STORE, 5'b10000, 16'h0008);
    #1;
    chk("store", {1'b1, 16'h0008}, {chunk_poison, chunk_mask});
    apb(0, OFF_CACHE_ESR, '0);
    chk("store rw", 1'b1, rd[CACHE_RW_POS]);
    u_mem_ctrl_model.acc(K_ATOMIC, 5'b10000, 16'h0002);
    #1;
    chk("atomic", 1'b1, update_abort);
    u_mem_ctrl_model.acc(K_PSTORE, 5'b10000, 16'h0004);
    #1;
    chk("pstore", 2'b11, {update_abort, chunk_poison});
    apb(1, OFF_MEM_ESR, 32'h003f_0000);
    u_mem_ctrl_model.acc(K_WRBACK, 5'b00100, '0);
    #1;
    chk("drop", 2'b10, {access_drop, load_ret_err});
    u_mem_ctrl_model.acc(K_BSTORE, 5'b00100, '0);
    #1;
    chk("bstore drop", 2'b10, {access_drop, chunk_poison});
    apb(0, OFF_MEM_ESR, '0);
    chk("silent", 6'h00, rd[21:16]);
    u_mem_ctrl_model.acc(K_LOAD, 5'b00100, '0);
    #1;
    chk("oob line", {1'b1, 16'hffff}, {chunk_poison, chunk_mask});
    u_mem_ctrl_model.acc(K_LOAD, 5'b01000, 16'h0001);
    apb(0, OFF_MEM_ESR, '0);
    chk("dbu", 1'b1, rd[MEM_FLAG_POS + MF_DBU]);
    chk("fbu", 1'b1, rd[MEM_FLAG_POS + MF_FBU]);
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    #400_000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    {presetn, psel, penable, pwrite, ie, hp} = 6'b000011;
    {paddr, pwdata} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_scrub();
    t_precise();
    t_pend();
    t_after();
    report_and_stop();
  end
endmodule
`default_nettype wire
